// ---- pump_cmd_regs.svh ----
/*
 * Register offsets, command codes, ASCII codes and timing counts of the
 * pump command handler. Assumes byte addresses on a 32-bit APB bus.
 */
`ifndef PUMP_CMD_REGS_SVH
`define PUMP_CMD_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CMD        8'h00
`define OFS_STAT_RATE  8'h04
`define OFS_STAT_TIME  8'h08
`define OFS_STAT_VOL   8'h0C
`define OFS_FLAGS_A    8'h10
`define OFS_FLAGS_B    8'h14
`define OFS_IVOL       8'h18
`define OFS_WVOL       8'h1C
`define OFS_ITIME_S    8'h20
`define OFS_WTIME_S    8'h24
`define OFS_WRATE      8'h28
`define OFS_LIM_MIN    8'h2C
`define OFS_LIM_MAX    8'h30
`define OFS_RAMP_START 8'h34
`define OFS_RAMP_END   8'h38
`define OFS_RAMP_TIME  8'h3C
`define OFS_TVOL       8'h40
`define OFS_TTIME      8'h44
`define OFS_VALID      8'h48
`define OFS_INPUT      8'h4C
`define OFS_OUTCTL     8'h50
`define OFS_ADDR       8'h54

// ****************************************
// Command codes, written to the command register
// ****************************************
`define CMD_CLR_IVOL   4'h1
`define CMD_CLR_WVOL   4'h2
`define CMD_CLR_VOL    4'h3
`define CMD_CLR_TVOL   4'h4
`define CMD_CLR_ITIME  4'h5
`define CMD_CLR_WTIME  4'h6
`define CMD_CLR_TIME   4'h7
`define CMD_CLR_TTIME  4'h8
`define CMD_WRATE_MAX  4'h9
`define CMD_WRATE_MIN  4'hA
`define CMD_CLR_FLAGS  4'hB

// ****************************************
// Characters, words, limits and reset values
// ****************************************
`define CH_I    8'h49
`define CH_W    8'h57
`define CH_S    8'h53
`define CH_T    8'h54
`define CH_DOT  8'h2E
`define CH_CASE 8'h20
`define CH_CR   8'h0D
`define CH_LF   8'h0A
`define WORD_HIGH 32'h6867_6948
`define WORD_LOW  32'h2077_6F4C
`define ADDR_MAX  32'h0000_0063
`define RST_WRATE 32'h0000_0000
`define MS_PER_S  10'h3E7

// ****************************************
// Timing
// ****************************************
`define CLK_HZ          40000000
`define TICK_HZ         56000000
`define GRAIN_MS        1
`define TICKS_PER_GRAIN (`TICK_HZ / 1000 * `GRAIN_MS)
`define CYC_PER_GRAIN   (`CLK_HZ / 1000 * `GRAIN_MS)

`endif

// ---- pump_cmd_pkg.sv ----
/*
 * Types of the pump command handler: bus carriers and sensed pump state.
 * Assumes an APB master with 32-bit data.
 */
package pump_cmd_pkg;

  // APB request from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  // Pump state sensed from the motor drive and pins
  typedef struct packed {
    logic motor_run;
    logic dir_wd;
    logic limit_inf;
    logic limit_wd;
    logic stall;
    logic trigger;
    logic dir_port_wd;
  } sense_t;

endpackage

// ---- pump_text_command_handler.sv ----
/*
 * Command handler of a syringe pump: APB register file for rates, ramps,
 * volumes, times, targets, digital I/O and the raw status line.
 * Assumes synchronous pump sense inputs and a host that formats text.
 */
`include "pump_cmd_regs.svh"

module pump_text_command_handler #(
  parameter int unsigned MS_CYCLES = `CYC_PER_GRAIN,
  parameter logic [31:0] RATE_MIN  = 32'h0000_03E8,
  parameter logic [31:0] RATE_MAX  = 32'h3B9A_CA00
) (
  input  logic                   i_clk,
  input  logic                   i_rst_n,
  input  pump_cmd_pkg::apb_req_t i_apb,
  output pump_cmd_pkg::apb_rsp_t o_apb,
  input  pump_cmd_pkg::sense_t   i_sense,
  input  logic [31:0]            i_infuse_rate,
  input  logic                   i_quick_mode,
  output logic [1:0]             o_out_port,
  output logic                   o_sync
);
  import pump_cmd_pkg::*;

  // ****************************************
  // Bus decode
  // ****************************************
  logic [7:0]  ofs;
  logic        wr_ok;
  logic        setup_done;
  logic        gated;
  logic        bad;
  logic        hit;
  logic [31:0] rdata;
  logic [3:0]  cmd;
  logic        cmd_go;

  // Taken at the edge where the registered pready is seen
  assign ofs        = i_apb.paddr[7:0];
  assign setup_done = i_apb.psel & i_apb.penable & ~o_apb.pready;
  assign wr_ok      = i_apb.psel & i_apb.penable & o_apb.pready & i_apb.pwrite & ~o_apb.pslverr;
  assign cmd        = i_apb.pwdata[3:0];
  assign cmd_go     = wr_ok & (ofs == `OFS_CMD);

  // Settings that only quick mode accepts
  assign gated = (ofs == `OFS_CMD) | (ofs == `OFS_WRATE) | (ofs == `OFS_RAMP_START)
               | (ofs == `OFS_RAMP_END) | (ofs == `OFS_RAMP_TIME)
               | (ofs == `OFS_TVOL) | (ofs == `OFS_TTIME);

  // ****************************************
  // Pump state
  // ****************************************
  sense_t      sense_q;
  logic [31:0] wrate;
  logic [31:0] ramp_start;
  logic [31:0] ramp_end;
  logic [31:0] ramp_time;
  logic        ramp_valid;
  logic [31:0] tvol;
  logic        tvol_valid;
  logic [31:0] ttime;
  logic        ttime_valid;
  logic [6:0]  pump_addr;
  logic [1:0]  limit_hit;
  logic        stall_hit;
  logic        target_hit;
  logic [31:0] grain_cnt;
  logic        grain;
  logic [31:0] ticks [2];
  logic [9:0]  msec  [2];
  logic [31:0] secs  [2];
  logic [31:0] vol   [2];
  logic [1:0]  clr_vol;
  logic [1:0]  clr_time;
  logic        cur;
  logic [31:0] rate_now;
  logic [7:0]  flag1;
  logic [7:0]  flag2;
  logic [7:0]  flag3;
  logic [7:0]  flag4;
  logic [7:0]  flag5;
  logic [7:0]  flag6;

  // Inputs sampled once; every flag but limit and stall, which take i_sense directly, looks at this copy
  always_ff @(posedge i_clk) begin
    sense_q <= i_sense;
  end

  assign cur      = sense_q.dir_wd;
  // Rate of the selected direction, zero while idle
  assign rate_now = !sense_q.motor_run ? 32'h0 : (cur ? wrate : i_infuse_rate);

  // ****************************************
  // Bus answer
  // ****************************************
  // Unmapped, gated outside quick mode, or address or withdraw rate out of range
  assign bad = ~hit
             | (i_apb.pwrite & gated & ~i_quick_mode)
             | (i_apb.pwrite & (ofs == `OFS_ADDR) & (i_apb.pwdata > `ADDR_MAX))
             | (i_apb.pwrite & (ofs == `OFS_WRATE)
                & ((i_apb.pwdata < RATE_MIN) | (i_apb.pwdata > RATE_MAX)));

  // Read multiplexer
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0;
    case (ofs)
      `OFS_CMD:        rdata = 32'h0;
      `OFS_STAT_RATE:  rdata = rate_now;
      `OFS_STAT_TIME:  rdata = ticks[cur];
      `OFS_STAT_VOL:   rdata = vol[cur];
      `OFS_FLAGS_A:    rdata = {flag4, flag3, flag2, flag1};
      `OFS_FLAGS_B:    rdata = {`CH_LF, `CH_CR, flag6, flag5};
      `OFS_IVOL:       rdata = vol[0];
      `OFS_WVOL:       rdata = vol[1];
      `OFS_ITIME_S:    rdata = secs[0];
      `OFS_WTIME_S:    rdata = secs[1];
      `OFS_WRATE:      rdata = wrate;
      `OFS_LIM_MIN:    rdata = RATE_MIN;
      `OFS_LIM_MAX:    rdata = RATE_MAX;
      `OFS_RAMP_START: rdata = ramp_start;
      `OFS_RAMP_END:   rdata = ramp_end;
      `OFS_RAMP_TIME:  rdata = ramp_time;
      `OFS_TVOL:       rdata = tvol;
      `OFS_TTIME:      rdata = ttime;
      `OFS_VALID:      rdata = {29'h0, ttime_valid, tvol_valid, ramp_valid};
      `OFS_INPUT:      rdata = sense_q.trigger ? `WORD_HIGH : `WORD_LOW;
      `OFS_OUTCTL:     rdata = {29'h0, o_sync, o_out_port};
      `OFS_ADDR:       rdata = {23'h0, (pump_addr == 7'h00), 1'b0, pump_addr};
      default:         hit   = 1'b0;
    endcase
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_apb <= '0;
    end else begin
      o_apb.pready  <= setup_done;
      o_apb.pslverr <= setup_done & bad;
      o_apb.prdata  <= setup_done ? rdata : 32'h0;
    end
  end

  // ****************************************
  // Settings
  // ****************************************
  // Withdraw rate, value or extreme
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wrate <= `RST_WRATE;
    end else if (wr_ok && ofs == `OFS_WRATE) begin
      wrate <= i_apb.pwdata;
    end else if (cmd_go && cmd == `CMD_WRATE_MAX) begin
      wrate <= RATE_MAX;
    end else if (cmd_go && cmd == `CMD_WRATE_MIN) begin
      wrate <= RATE_MIN;
    end
  end

  // Withdraw ramp; time write arms it, target time clear cancels it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ramp_start <= 32'h0;
      ramp_end   <= 32'h0;
      ramp_time  <= 32'h0;
      ramp_valid <= 1'b0;
    end else begin
      if (wr_ok && ofs == `OFS_RAMP_START) ramp_start <= i_apb.pwdata;
      if (wr_ok && ofs == `OFS_RAMP_END) ramp_end <= i_apb.pwdata;
      if (wr_ok && ofs == `OFS_RAMP_TIME) begin
        ramp_time  <= i_apb.pwdata;
        ramp_valid <= 1'b1;
      end else if (cmd_go && cmd == `CMD_CLR_TTIME) begin
        ramp_valid <= 1'b0;
      end
    end
  end

  // Targets, set by writes and zeroed by commands
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tvol        <= 32'h0;
      tvol_valid  <= 1'b0;
      ttime       <= 32'h0;
      ttime_valid <= 1'b0;
    end else begin
      if (wr_ok && ofs == `OFS_TVOL) begin
        tvol       <= i_apb.pwdata;
        tvol_valid <= 1'b1;
      end else if (cmd_go && cmd == `CMD_CLR_TVOL) begin
        tvol       <= 32'h0;
        tvol_valid <= 1'b0;
      end
      if (wr_ok && ofs == `OFS_TTIME) begin
        ttime       <= i_apb.pwdata;
        ttime_valid <= 1'b1;
      end else if (cmd_go && cmd == `CMD_CLR_TTIME) begin
        ttime       <= 32'h0;
        ttime_valid <= 1'b0;
      end
    end
  end

  // Output ports, sync port and chain address
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_port <= 2'b00;
      o_sync     <= 1'b0;
      pump_addr  <= 7'h00;
    end else begin
      if (wr_ok && ofs == `OFS_OUTCTL) begin
        o_out_port <= i_apb.pwdata[1:0];
        o_sync     <= i_apb.pwdata[2];
      end
      if (wr_ok && ofs == `OFS_ADDR) pump_addr <= i_apb.pwdata[6:0];
    end
  end

  // ****************************************
  // Elapsed time and volume per direction
  // ****************************************
  // Millisecond grain
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      grain_cnt <= 32'h0;
      grain     <= 1'b0;
    end else begin
      grain     <= (grain_cnt == MS_CYCLES - 1);
      grain_cnt <= (grain_cnt == MS_CYCLES - 1) ? 32'h0 : grain_cnt + 32'h1;
    end
  end

  assign clr_vol[0]  = cmd_go & (cmd == `CMD_CLR_IVOL | cmd == `CMD_CLR_VOL);
  assign clr_vol[1]  = cmd_go & (cmd == `CMD_CLR_WVOL | cmd == `CMD_CLR_VOL);
  assign clr_time[0] = cmd_go & (cmd == `CMD_CLR_ITIME | cmd == `CMD_CLR_TIME);
  assign clr_time[1] = cmd_go & (cmd == `CMD_CLR_WTIME | cmd == `CMD_CLR_TIME);

  // Counters of infuse (0) and withdraw (1); volume adds the rate each second
  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic run_d;
    assign run_d = grain & sense_q.motor_run & (sense_q.dir_wd == d[0]);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        ticks[d] <= 32'h0;
        msec[d]  <= 10'h0;
        secs[d]  <= 32'h0;
      end else if (clr_time[d]) begin
        ticks[d] <= 32'h0;
        msec[d]  <= 10'h0;
        secs[d]  <= 32'h0;
      end else if (run_d) begin
        ticks[d] <= ticks[d] + 32'(`TICKS_PER_GRAIN);
        msec[d]  <= (msec[d] == `MS_PER_S) ? 10'h0 : msec[d] + 10'h1;
        if (msec[d] == `MS_PER_S) secs[d] <= secs[d] + 32'h1;
      end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        vol[d] <= 32'h0;
      end else if (clr_vol[d]) begin
        vol[d] <= 32'h0;
      end else if (run_d && msec[d] == `MS_PER_S) begin
        vol[d] <= vol[d] + rate_now;
      end
    end
  end

  // ****************************************
  // Sticky events; a set wins over a clear
  // ****************************************
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      limit_hit  <= 2'b00;
      stall_hit  <= 1'b0;
      target_hit <= 1'b0;
    end else begin
      if (i_sense.limit_inf) limit_hit <= 2'b01;
      else if (i_sense.limit_wd) limit_hit <= 2'b10;
      else if (cmd_go && cmd == `CMD_CLR_FLAGS) limit_hit <= 2'b00;
      stall_hit  <= i_sense.stall | (stall_hit & ~(cmd_go && cmd == `CMD_CLR_FLAGS));
      target_hit <= (tvol_valid & (vol[cur] >= tvol)) | (ttime_valid & (secs[cur] >= ttime))
                  | (target_hit & ~(cmd_go && cmd == `CMD_CLR_FLAGS));
    end
  end

  // ****************************************
  // Status flag characters
  // ****************************************
  assign flag1 = (cur ? `CH_W : `CH_I) | (sense_q.motor_run ? 8'h00 : `CH_CASE);
  assign flag2 = limit_hit[0] ? `CH_I : (limit_hit[1] ? `CH_W : `CH_DOT);
  assign flag3 = stall_hit ? `CH_S : `CH_DOT;
  assign flag4 = sense_q.trigger ? `CH_T : `CH_DOT;
  assign flag5 = sense_q.dir_port_wd ? `CH_W : `CH_I;
  assign flag6 = target_hit ? `CH_T : `CH_DOT;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr(logic [7:0] a);
    wr_ok && ofs == a;
  endsequence
  sequence s_cmd(logic [3:0] c);
    s_wr(`OFS_CMD) ##0 cmd == c;
  endsequence

  property p_bus_pulse;
    setup_done |=> o_apb.pready ##1 !o_apb.pready;
  endproperty
  a_bus_pulse: assert property (p_bus_pulse) else $error("pready not one cycle");

  property p_flag_dir;
    ##1 flag1 == (($past(i_sense.dir_wd) ? `CH_W : `CH_I)
                  | ($past(i_sense.motor_run) ? 8'h00 : `CH_CASE));
  endproperty
  a_flag_dir: assert property (p_flag_dir) else $error("direction flag wrong");

  property p_limit;
    i_sense.limit_wd && !i_sense.limit_inf |=> flag2 == `CH_W;
  endproperty
  a_limit: assert property (p_limit) else $error("limit flag missed");

  property p_stall;
    i_sense.stall |=> flag3 == `CH_S ##1 flag3 == `CH_S || $past(cmd_go);
  endproperty
  a_stall: assert property (p_stall) else $error("stall flag missed");

  property p_trig;
    ##1 flag4 == ($past(i_sense.trigger) ? `CH_T : `CH_DOT);
  endproperty
  a_trig: assert property (p_trig) else $error("trigger flag wrong");

  property p_outctl;
    s_wr(`OFS_OUTCTL) |=> o_out_port == $past(i_apb.pwdata[1:0])
                          && o_sync == $past(i_apb.pwdata[2]);
  endproperty
  a_outctl: assert property (p_outctl) else $error("output ports not driven");

  property p_ramp_clr;
    s_cmd(`CMD_CLR_TTIME) |=> !ramp_valid && !ttime_valid;
  endproperty
  a_ramp_clr: assert property (p_ramp_clr) else $error("ramp not cancelled");

  property p_quick;
    !i_quick_mode && o_apb.pready && i_apb.pwrite && ofs == `OFS_WRATE |=> $stable(wrate);
  endproperty
  a_quick: assert property (p_quick) else $error("rate changed outside quick mode");

  property p_addr;
    o_apb.pready && i_apb.pwrite && ofs == `OFS_ADDR && i_apb.pwdata > `ADDR_MAX
      |=> $stable(pump_addr);
  endproperty
  a_addr: assert property (p_addr) else $error("address above range taken");

  property p_tick;
    g_dir[0].run_d && !clr_time[0] |=> ticks[0] == $past(ticks[0]) + 32'(`TICKS_PER_GRAIN);
  endproperty
  a_tick: assert property (p_tick) else $error("tick count step wrong");

  property p_target;
    ttime_valid && secs[cur] >= ttime |=> flag6 == `CH_T;
  endproperty
  a_target: assert property (p_target) else $error("target flag missed");

endmodule // pump_text_command_handler

// ---- pump_apb_host.sv ----
/*
 * APB host model standing in for the controlling computer.
 * Assumes one clock and one calling process at a time.
 */
module pump_apb_host (
  input  logic                   i_clk,
  output pump_cmd_pkg::apb_req_t o_req,
  input  pump_cmd_pkg::apb_rsp_t i_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  import pump_cmd_pkg::*;

  initial o_req = '0;

  // ****
  // One transfer: setup, access until pready, release
  // ****
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    ok = 1'b0;
    q  = 32'h0;
    e  = 1'b0;
    @(posedge i_clk);
    o_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {24'h0, a}, pwdata: d};
    @(posedge i_clk);
    o_req.penable <= 1'b1;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge i_clk);
      if (i_rsp.pready === 1'b1) begin
        ok = 1'b1;
        q  = i_rsp.prdata;
        e  = i_rsp.pslverr;
      end
    end
    // Released bus shows inverted leftovers, not the old request
    o_req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~{24'h0, a}, pwdata: ~d};
  endtask
endmodule // pump_apb_host

// ---- pump_text_command_handler_tb.sv ----
/*
 * Self-checking bench of the pump command handler.
 * Assumes the APB host model and a shortened millisecond grain.
 */
`include "pump_cmd_regs.svh"

module pump_text_command_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pump_cmd_pkg::*;

  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        quick = 1'b1;
  sense_t      sense = '0;
  logic [31:0] irate = 32'h0;
  logic [31:0] seed  = 32'hC81C;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [1:0]  port;
  logic        sync;
  int          fails = 0;
  int          total_checks = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  pump_text_command_handler #(.MS_CYCLES(4)) dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_apb(req), .o_apb(rsp), .i_sense(sense),
    .i_infuse_rate(irate), .i_quick_mode(quick), .o_out_port(port), .o_sync(sync));

  pump_apb_host host (.i_clk(clk), .o_req(req), .i_rsp(rsp));

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] flags_a(input sense_t s, input logic [7:0] lim,
                                          input logic st);
    return {s.trigger ? `CH_T : `CH_DOT, st ? `CH_S : `CH_DOT, lim,
            (s.dir_wd ? `CH_W : `CH_I) | (s.motor_run ? 8'h00 : `CH_CASE)};
  endfunction

  function automatic logic [31:0] flags_b(input sense_t s, input logic tr);
    return {`CH_LF, `CH_CR, tr ? `CH_T : `CH_DOT, s.dir_port_wd ? `CH_W : `CH_I};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic xe, output logic [31:0] q);
    logic e;
    logic ok;
    host.xfer(w, a, d, q, e, ok);
    if (!ok) begin
      fails++;
      end_sim();
    end else begin
      chk("pslverr", {31'h0, e}, {31'h0, xe});
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, 1'b0, q);
    chk(n, q, x);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe = 1'b0);
    logic [31:0] q;
    acc(1'b1, a, d, xe, q);
  endtask

  // ****
  // Main sequence
  // ****
  initial begin
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] ir;
    sense_t      v;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(`OFS_WRATE, `RST_WRATE, "wrate reset");
    rd(`OFS_VALID, 32'h0, "valid reset");
    rd(`OFS_CMD, 32'h0, "cmd reads zero");
    chk("ports reset", {29'h0, sync, port}, 32'h0);
    // Random levels on the non-sticky sense inputs
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = '{motor_run: seed[0], dir_wd: seed[1], trigger: seed[2],
            dir_port_wd: seed[3], default: 1'b0};
      sense <= v;
      rd(`OFS_FLAGS_A, flags_a(v, `CH_DOT, 1'b0), "flags a");
      rd(`OFS_FLAGS_B, flags_b(v, 1'b0), "flags b");
      rd(`OFS_INPUT, v.trigger ? `WORD_HIGH : `WORD_LOW, "input");
    end
    // Sticky stall and limit flags
    sense <= v | sense_t'(7'h0C);
    @(posedge clk);
    sense <= v;
    rd(`OFS_FLAGS_A, flags_a(v, `CH_W, 1'b1), "stall wd");
    sense.limit_inf <= 1'b1;
    @(posedge clk);
    sense <= v;
    rd(`OFS_FLAGS_A, flags_a(v, `CH_I, 1'b1), "limit inf");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_FLAGS});
    rd(`OFS_FLAGS_A, flags_a(v, `CH_DOT, 1'b0), "flags clr");
    // Output and sync ports, every combination
    for (int k = 0; k < 8; k++) begin
      wr(`OFS_OUTCTL, k);
      #1;
      chk("ports", {29'h0, sync, port}, k);
    end
    // Withdraw rate, given in fL/s by the host
    seed = lfsr(seed);
    r = 32'h3E8 + {8'h0, seed[23:0]};
    wr(`OFS_WRATE, r);
    wr(`OFS_WRATE, 32'h3E7, 1'b1);
    rd(`OFS_WRATE, r, "wrate");
    wr(`OFS_CMD, {28'h0, `CMD_WRATE_MAX});
    rd(`OFS_WRATE, 32'h3B9A_CA00, "wrate max");
    wr(`OFS_CMD, {28'h0, `CMD_WRATE_MIN});
    rd(`OFS_WRATE, 32'h0000_03E8, "wrate min");
    rd(`OFS_LIM_MAX, 32'h3B9A_CA00, "lim max");
    rd(`OFS_LIM_MIN, 32'h0000_03E8, "lim min");
    // Settings refused outside quick mode
    quick <= 1'b0;
    wr(`OFS_WRATE, r, 1'b1);
    wr(`OFS_CMD, {28'h0, `CMD_CLR_IVOL}, 1'b1);
    rd(`OFS_WRATE, 32'h0000_03E8, "wrate held");
    quick <= 1'b1;
    wr(`OFS_WRATE, r);
    // Ramp and target time
    wr(`OFS_RAMP_START, r);
    wr(`OFS_RAMP_END, r);
    wr(`OFS_RAMP_TIME, 32'h5);
    rd(`OFS_VALID, 32'h1, "ramp set");
    rd(`OFS_RAMP_START, r, "ramp start");
    rd(`OFS_RAMP_END, r, "ramp end");
    rd(`OFS_RAMP_TIME, 32'h5, "ramp time");
    wr(`OFS_TTIME, 32'h1);
    rd(`OFS_VALID, 32'h5, "ttime set");
    // Infuse run of 1500 grains
    wr(`OFS_CMD, {28'h0, `CMD_CLR_TIME});
    wr(`OFS_CMD, {28'h0, `CMD_CLR_VOL});
    seed = lfsr(seed);
    ir = {8'h0, seed[23:0]};
    v = '{motor_run: 1'b1, default: 1'b0};
    sense <= v;
    irate <= ir;
    rd(`OFS_STAT_RATE, ir, "rate inf");
    rd(`OFS_FLAGS_A, flags_a(v, `CH_DOT, 1'b0), "running");
    // Two reads of 4 cycles plus 5992 gives 6000 running cycles
    repeat (5992) @(posedge clk);
    v.motor_run = 1'b0;
    sense <= v;
    rd(`OFS_ITIME_S, 32'h1, "itime");
    rd(`OFS_IVOL, ir, "ivol");
    rd(`OFS_STAT_VOL, ir, "stat vol");
    rd(`OFS_STAT_RATE, 32'h0, "rate idle");
    rd(`OFS_FLAGS_B, flags_b(v, 1'b1), "target");
    acc(1'b0, `OFS_STAT_TIME, 32'h0, 1'b0, q);
    chk("tick grain", q % 32'd56000, 32'h0);
    chk("ms count", {31'h0, (q / 32'd56000 - 32'd1499) < 32'd3}, 32'h1);
    // Short withdraw run
    v = '{motor_run: 1'b1, dir_wd: 1'b1, default: 1'b0};
    sense <= v;
    rd(`OFS_STAT_RATE, r, "rate wd");
    rd(`OFS_STAT_VOL, 32'h0, "vol wd");
    rd(`OFS_WVOL, 32'h0, "wvol");
    rd(`OFS_WTIME_S, 32'h0, "wtime");
    v.motor_run = 1'b0;
    sense <= v;
    // Clear commands hit only their own counters
    wr(`OFS_CMD, {28'h0, `CMD_CLR_WVOL});
    rd(`OFS_IVOL, ir, "ivol kept");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_IVOL});
    rd(`OFS_IVOL, 32'h0, "ivol clr");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_WTIME});
    rd(`OFS_ITIME_S, 32'h1, "itime kept");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_ITIME});
    rd(`OFS_ITIME_S, 32'h0, "itime clr");
    wr(`OFS_TVOL, ir);
    rd(`OFS_TVOL, ir, "tvol");
    rd(`OFS_VALID, 32'h7, "tvol set");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_TVOL});
    rd(`OFS_TVOL, 32'h0, "tvol clr");
    wr(`OFS_CMD, {28'h0, `CMD_CLR_TTIME});
    rd(`OFS_VALID, 32'h0, "ramp cancel");
    rd(`OFS_TTIME, 32'h0, "ttime clr");
    // Chain address
    wr(`OFS_ADDR, `ADDR_MAX);
    wr(`OFS_ADDR, 32'h64, 1'b1);
    rd(`OFS_ADDR, `ADDR_MAX, "addr slave");
    wr(`OFS_ADDR, 32'h0);
    rd(`OFS_ADDR, 32'h100, "addr master");
    // Unmapped offset
    acc(1'b0, 8'h58, 32'h0, 1'b1, q);
    end_sim();
  end
endmodule // pump_text_command_handler_tb
